/* src/flash_program_sequencer.sv */
// flash programming sequencer: keyed control writes, latch and busy logic
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module flash_program_sequencer #(
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
  input wire logic clk_i,               // 125 MHz clock
  input wire logic rst_i,               // synchronous reset, active high
  flash_seq_if.flash bus,               // core side
  output logic [7:0] security_byte_o,   // programmed security byte
  output logic prog_done_o              // one-cycle pulse at programming end
);
  // registered state and flags
  logic [7:0] flash_control_reg;
  logic [7:0] latch_reg;
  logic latch_loaded_reg;
  logic programming_busy_flag;
  logic sequence_error_flag;
  logic program_space_select;
  logic [31:0] count_reg;
  logic [7:0] key1_reg;
  flash_seq_pkg::seq_state_t state_reg;

  // decoded strobes and qualifiers
  logic key1_hit;
  logic key2_hit;
  logic prog_ok;
  logic rst_ok;
  logic prog_empty;
  logic prog_end;
  logic launch_go;
  logic ctrl_write_ok;
  logic seq_break;
  logic latch_load;
  logic latch_clear;
  logic sw_clear;
  logic [7:0] status_word;

  // key decode on a control write
  assign key1_hit = bus.ctrl_we && bus.ctrl_wdata[7:4] == flash_seq_pkg::KEY1_NIBBLE;
  assign key2_hit = bus.ctrl_we && bus.ctrl_wdata[7:4] == flash_seq_pkg::KEY2_NIBBLE;
  // boot flash is the only place the keys are honoured; busy shuts them out
  assign prog_ok = state_reg == flash_seq_pkg::SEQ_KEYED && bus.ctrl_we && bus.boot_exec &&
                   key1_reg == flash_seq_pkg::KEY_PROG_1 && bus.ctrl_wdata == flash_seq_pkg::KEY_PROG_2;
  assign rst_ok = state_reg == flash_seq_pkg::SEQ_KEYED && bus.ctrl_we && bus.boot_exec &&
                  key1_reg == flash_seq_pkg::KEY_RST_1 && bus.ctrl_wdata == flash_seq_pkg::KEY_RST_2;
  assign prog_empty = prog_ok && !latch_loaded_reg;
  // a launch only goes ahead with data waiting in the latch
  assign launch_go = prog_ok && latch_loaded_reg;
  assign prog_end = state_reg == flash_seq_pkg::SEQ_PROG && count_reg == 32'(PROG_CYCLES - 1);
  // control writes are frozen for the whole programming run
  assign ctrl_write_ok = bus.ctrl_we && state_reg != flash_seq_pkg::SEQ_PROG;
  // a pending first key met by anything but a second key
  assign seq_break = state_reg == flash_seq_pkg::SEQ_KEYED && bus.ctrl_we && !key2_hit;
  // external-move write; only the mapped security byte latch takes it
  assign latch_load = bus.latch_we && program_space_select && state_reg != flash_seq_pkg::SEQ_PROG &&
                      bus.latch_addr == flash_seq_pkg::LATCH_ADDR;
  // automatic clear after programming, manual clear on the reset keys
  assign latch_clear = prog_end || rst_ok;
  // writing a zero to the error bit clears it
  assign sw_clear = bus.stat_we && !bus.stat_wdata[flash_seq_pkg::ST_SEQUENCE_ERROR_FLAG_BIT];

  // key sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= flash_seq_pkg::SEQ_IDLE;
    end else begin
      case (state_reg)
        flash_seq_pkg::SEQ_IDLE: begin
          if (key1_hit) begin
            state_reg <= flash_seq_pkg::SEQ_KEYED;
          end
        end
        flash_seq_pkg::SEQ_KEYED: begin
          if (launch_go) begin
            state_reg <= flash_seq_pkg::SEQ_PROG;
          end else if (bus.ctrl_we) begin
            state_reg <= flash_seq_pkg::SEQ_IDLE;
          end
        end
        flash_seq_pkg::SEQ_PROG: begin
          // writes are swallowed here, no new sequence starts
          if (prog_end) begin
            state_reg <= flash_seq_pkg::SEQ_IDLE;
          end
        end
        default: begin
          // unreachable; recovers from a corrupted state
          state_reg <= flash_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // first key held for comparison with the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key1_reg <= flash_seq_pkg::CONTROL_RESET;
    end else if (state_reg == flash_seq_pkg::SEQ_IDLE && key1_hit) begin
      key1_reg <= bus.ctrl_wdata;
    end
  end

  // programming timer, counted in clock cycles
  // the run length therefore scales with the clock; retune the count if the clock moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (state_reg == flash_seq_pkg::SEQ_KEYED) begin
      count_reg <= '0;
    end else if (state_reg == flash_seq_pkg::SEQ_PROG) begin
      count_reg <= count_reg + 32'd1;
    end
  end

  // control register read-back value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_control_reg <= flash_seq_pkg::CONTROL_RESET;
    end else if (ctrl_write_ok) begin
      flash_control_reg <= bus.ctrl_wdata;
    end
  end

  // program-space select; key values leave it alone
  // so that a keyed launch keeps the security byte mapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_space_select <= 1'b0;
    end else if (ctrl_write_ok) begin
      if (bus.ctrl_wdata == flash_seq_pkg::MAP_SECURITY_VAL) begin
        program_space_select <= 1'b1;
      end else if (!key1_hit && !key2_hit) begin
        program_space_select <= bus.ctrl_wdata[flash_seq_pkg::CT_PSEL_BIT];
      end
    end
  end

  // column latch data: loads only when mapped, frozen while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= flash_seq_pkg::LATCH_RESET;
    end else if (latch_clear) begin
      latch_reg <= flash_seq_pkg::LATCH_RESET;
    end else if (latch_load) begin
      latch_reg <= bus.latch_wdata;
    end
  end

  // latch holds data waiting to be programmed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_loaded_reg <= 1'b0;
    end else if (latch_clear) begin
      latch_loaded_reg <= 1'b0;
    end else if (latch_load) begin
      latch_loaded_reg <= 1'b1;
    end
  end

  // busy flag; its own flop so the status read is a plain register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      programming_busy_flag <= 1'b0;
    end else if (launch_go) begin
      programming_busy_flag <= 1'b1;
    end else if (prog_end) begin
      programming_busy_flag <= 1'b0;
    end
  end

  // byte committed at the end of a run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      security_byte_o <= flash_seq_pkg::LATCH_RESET;
    end else if (prog_end) begin
      security_byte_o <= latch_reg;
    end
  end

  // completion pulse, in step with the committed byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_done_o <= 1'b0;
    end else begin
      prog_done_o <= prog_end;
    end
  end

  // sequence error: a new error wins over a software clear
  // so an error in the clearing cycle is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequence_error_flag <= 1'b0;
    end else if (seq_break || prog_empty) begin
      sequence_error_flag <= 1'b1;
    end else if (prog_end) begin
      sequence_error_flag <= 1'b0;
    end else if (sw_clear) begin
      sequence_error_flag <= 1'b0;
    end
  end

  // read-back of both registers
  assign status_word = {5'h00, latch_loaded_reg, sequence_error_flag, programming_busy_flag};
  assign bus.ctrl_rdata = flash_control_reg;
  assign bus.stat_rdata = status_word;
endmodule // flash_program_sequencer
`default_nettype wire

/* src/flash_seq_pkg.sv */
// constants and types shared by the flash programming sequencer ends
// Function
// - writing 0Ch selects program space, maps security byte
// - core loads latch at address zero first
// - 54h then A4h launches, boot flash only
// - busy flag high while programming runs
// - core masks interrupts around keyed sequences (flash_core_master does not; irq_o is not gated by its key states)
// - latches cleared automatically after successful write
// - 56h then A6h resets latches, boot flash
// - first key not followed by second sets error
// - launch with empty latches sets error
// - software write clears the error bit
// - correct programming completion clears error bit
// - core checks status after each page
package flash_seq_pkg;
  localparam logic [7:0] MAP_SECURITY_VAL = 8'h0C;
  localparam logic [7:0] KEY_PROG_1 = 8'h54;
  localparam logic [7:0] KEY_PROG_2 = 8'hA4;
  localparam logic [7:0] KEY_RST_1 = 8'h56;
  localparam logic [7:0] KEY_RST_2 = 8'hA6;
  localparam logic [3:0] KEY1_NIBBLE = 4'h5;
  localparam logic [3:0] KEY2_NIBBLE = 4'hA;
  localparam logic [15:0] LATCH_ADDR = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam int PROG_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // status bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SEQUENCE_ERROR_FLAG_BIT = 1;
  localparam int ST_LOADED_BIT = 2;
  // control bit positions
  localparam int CT_PSEL_BIT = 3;
  // wishbone offsets of the controller
  localparam logic [3:0] WB_CMD_ADDR = 4'h0;
  localparam logic [3:0] WB_DATA_ADDR = 4'h4;
  localparam logic [3:0] WB_STAT_ADDR = 4'h8;
  localparam logic [3:0] WB_IRQ_STAT_ADDR = 4'hC;
  localparam logic [3:0] WB_IRQ_MASK_ADDR = 4'h1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  // controller commands
  localparam logic [2:0] CMD_MAP = 3'h1;
  localparam logic [2:0] CMD_LOAD = 3'h2;
  localparam logic [2:0] CMD_PROG = 3'h3;
  localparam logic [2:0] CMD_RESET_LATCH = 3'h4;
  localparam logic [2:0] CMD_CLEAR_ERR = 3'h5;
  localparam logic [2:0] CMD_RAW = 3'h6;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEYED, SEQ_PROG} seq_state_t;
endpackage

/* src/flash_seq_if.sv */
// interface joining the processor core end and the flash sequencer end
`timescale 1ns/10ps
`default_nettype none
interface flash_seq_if;
  logic ctrl_we;       // one-cycle write strobe to the control register
  logic [7:0] ctrl_wdata;
  logic stat_we;       // one-cycle write strobe to the status register
  logic [7:0] stat_wdata;
  logic latch_we;      // external-move write strobe
  logic [15:0] latch_addr;
  logic [7:0] latch_wdata;
  logic boot_exec;     // core runs from boot flash space
  logic [7:0] ctrl_rdata;
  logic [7:0] stat_rdata;
  modport core (output ctrl_we, ctrl_wdata, stat_we, stat_wdata, latch_we, latch_addr, latch_wdata,
                boot_exec, input ctrl_rdata, stat_rdata);
  modport flash (input ctrl_we, ctrl_wdata, stat_we, stat_wdata, latch_we, latch_addr, latch_wdata,
                 boot_exec, output ctrl_rdata, stat_rdata);
endinterface
`default_nettype wire

/* src/flash_core_master.sv */
// core end: wishbone-driven issuer of keyed flash sequences
`timescale 1ns/10ps
`default_nettype none
module flash_core_master (
  input wire logic clk_i,         // 125 MHz clock
  input wire logic rst_i,         // synchronous reset, active high
  input wire logic wb_cyc_i,      // wishbone cycle
  input wire logic wb_stb_i,      // wishbone strobe
  input wire logic wb_we_i,       // wishbone write enable
  input wire logic [3:0] wb_adr_i,// wishbone byte address
  input wire logic [3:0] wb_sel_i,// wishbone byte selects
  input wire logic [31:0] wb_dat_i,// wishbone write data
  output logic [31:0] wb_dat_o,   // wishbone read data
  output logic wb_ack_o,          // wishbone acknowledge
  output logic irq_o,             // level interrupt
  flash_seq_if.core bus           // sequencer side
);
  typedef enum logic [2:0] {M_IDLE, M_K1, M_K2, M_WAIT} mstate_t;
  mstate_t mstate_reg;
  logic [7:0] k1_reg;
  logic [7:0] k2_reg;
  logic [7:0] data_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic busy_prev_reg;
  logic req;
  logic [2:0] cmd;
  logic done_ev;
  logic err_ev;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd = wb_dat_i[2:0];
  assign done_ev = busy_prev_reg && !bus.stat_rdata[flash_seq_pkg::ST_BUSY_BIT];
  assign err_ev = bus.stat_rdata[flash_seq_pkg::ST_SEQUENCE_ERROR_FLAG_BIT];

  // wishbone slave: single-cycle ack, reads see live status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      case (wb_adr_i)
        flash_seq_pkg::WB_DATA_ADDR: wb_dat_o <= {24'h000000, data_reg};
        flash_seq_pkg::WB_STAT_ADDR: wb_dat_o <= {16'h0000, bus.ctrl_rdata, bus.stat_rdata};
        flash_seq_pkg::WB_IRQ_STAT_ADDR: wb_dat_o <= {30'h00000000, irq_stat_reg};
        default: wb_dat_o <= {21'h000000, irq_mask_reg, 5'h00, mstate_reg != M_IDLE, 3'h0};
      endcase
    end
  end

  // command sequencer: keys issued back to back; irq_o is not held off while they go out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mstate_reg <= M_IDLE;
      k1_reg <= 8'h00;
      k2_reg <= 8'h00;
      data_reg <= 8'h00;
      bus.ctrl_we <= 1'b0;
      bus.ctrl_wdata <= 8'h00;
      bus.stat_we <= 1'b0;
      bus.stat_wdata <= 8'h00;
      bus.latch_we <= 1'b0;
      bus.latch_addr <= flash_seq_pkg::LATCH_ADDR;
      bus.latch_wdata <= 8'h00;
      bus.boot_exec <= 1'b1;
    end else begin
      bus.ctrl_we <= 1'b0;
      bus.stat_we <= 1'b0;
      bus.latch_we <= 1'b0;
      case (mstate_reg)
        M_IDLE: begin
          if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == flash_seq_pkg::WB_DATA_ADDR) begin
            data_reg <= wb_dat_i[7:0];
          end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == flash_seq_pkg::WB_CMD_ADDR) begin
            bus.boot_exec <= wb_dat_i[7];
            case (cmd)
              flash_seq_pkg::CMD_MAP: begin
                bus.ctrl_we <= 1'b1;
                bus.ctrl_wdata <= flash_seq_pkg::MAP_SECURITY_VAL;
              end
              flash_seq_pkg::CMD_LOAD: begin
                bus.latch_we <= 1'b1;
                bus.latch_addr <= flash_seq_pkg::LATCH_ADDR;
                bus.latch_wdata <= data_reg;
              end
              flash_seq_pkg::CMD_PROG: begin
                k1_reg <= flash_seq_pkg::KEY_PROG_1;
                k2_reg <= flash_seq_pkg::KEY_PROG_2;
                mstate_reg <= M_K1;
              end
              flash_seq_pkg::CMD_RESET_LATCH: begin
                k1_reg <= flash_seq_pkg::KEY_RST_1;
                k2_reg <= flash_seq_pkg::KEY_RST_2;
                mstate_reg <= M_K1;
              end
              flash_seq_pkg::CMD_CLEAR_ERR: begin
                bus.stat_we <= 1'b1;
                bus.stat_wdata <= 8'h00;
              end
              flash_seq_pkg::CMD_RAW: begin
                bus.ctrl_we <= 1'b1;
                bus.ctrl_wdata <= data_reg;
              end
              default: ;
            endcase
          end
        end
        M_K1: begin
          bus.ctrl_we <= 1'b1;
          bus.ctrl_wdata <= k1_reg;
          mstate_reg <= M_K2;
        end
        M_K2: begin
          bus.ctrl_we <= 1'b1;
          bus.ctrl_wdata <= k2_reg;
          mstate_reg <= M_WAIT;
        end
        M_WAIT: begin
          // one cycle for the status to settle before watching busy
          mstate_reg <= M_IDLE;
        end
        default: mstate_reg <= M_IDLE;
      endcase
    end
  end

  // sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      busy_prev_reg <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      busy_prev_reg <= bus.stat_rdata[flash_seq_pkg::ST_BUSY_BIT];
      irq_stat_reg[flash_seq_pkg::IRQ_DONE_BIT] <= done_ev ||
        (irq_stat_reg[flash_seq_pkg::IRQ_DONE_BIT] && !(req && wb_we_i &&
         wb_adr_i == flash_seq_pkg::WB_IRQ_STAT_ADDR && wb_dat_i[flash_seq_pkg::IRQ_DONE_BIT]));
      irq_stat_reg[flash_seq_pkg::IRQ_ERR_BIT] <= err_ev ||
        (irq_stat_reg[flash_seq_pkg::IRQ_ERR_BIT] && !(req && wb_we_i &&
         wb_adr_i == flash_seq_pkg::WB_IRQ_STAT_ADDR && wb_dat_i[flash_seq_pkg::IRQ_ERR_BIT]));
      if (req && wb_we_i && wb_adr_i == flash_seq_pkg::WB_IRQ_MASK_ADDR) begin
        irq_mask_reg <= wb_dat_i[1:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule // flash_core_master
`default_nettype wire

/* tb/flash_seq_properties.sv */
// concurrent checks on the core-to-sequencer interface
`timescale 1ns/10ps
`default_nettype none
module flash_seq_properties #(
  parameter int PROG_CYCLES = 4
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic ctrl_we, // control write strobe
  input wire logic [7:0] ctrl_wdata, // control write data
  input wire logic stat_we, // status write strobe
  input wire logic [7:0] stat_wdata, // status write data
  input wire logic latch_we, // latch write strobe
  input wire logic [15:0] latch_addr, // latch address
  input wire logic boot_exec, // running from boot flash
  input wire logic [7:0] ctrl_rdata, // control readback
  input wire logic [7:0] stat_rdata // status readback
);
  logic [7:0] key_reg;
  logic [15:0] busy_len_reg;
  logic psel_reg;
  wire logic busy = stat_rdata[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // pending first key; any next control write consumes it, keys are ignored while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_reg <= 8'h00;
    end else if (ctrl_we && !busy) begin
      key_reg <= (key_reg[7:4] == 4'h5) ? 8'h00 : ctrl_wdata;
    end
  end
  // program-space select as map writes set it; key values leave it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psel_reg <= 1'b0;
    end else if (ctrl_we && !busy && ctrl_wdata == 8'h0C) begin
      psel_reg <= 1'b1;
    end else if (ctrl_we && !busy && ctrl_wdata[7:4] != 4'h5 && ctrl_wdata[7:4] != 4'hA) begin
      psel_reg <= ctrl_wdata[3];
    end
  end
  // length of the current busy run in sampled cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) begin
      busy_len_reg <= 16'h0000;
    end else begin
      busy_len_reg <= busy_len_reg + 16'h0001;
    end
  end
  sequence s_pair(logic [7:0] k1, logic [7:0] k2);
    ctrl_we && !busy && key_reg == k1 && ctrl_wdata == k2;
  endsequence
  sequence s_launch;
    s_pair(flash_seq_pkg::KEY_PROG_1, flash_seq_pkg::KEY_PROG_2);
  endsequence
  AST_MAP: assert property (ctrl_we && !busy && ctrl_wdata == 8'h0C |=> ctrl_rdata == 8'h0C)
    else $error("map write not reflected in control register");
  AST_LOAD: assert property (latch_we && !busy && psel_reg && latch_addr == 16'h0000 |=> stat_rdata[2])
    else $error("latch write did not mark latch loaded");
  AST_NOLOAD: assert property (latch_we && !busy && !psel_reg && !stat_rdata[2] |=> !stat_rdata[2])
    else $error("latch loaded while security byte unmapped");
  AST_LAUNCH: assert property (s_launch ##0 (boot_exec && stat_rdata[2]) |=> busy)
    else $error("launch keys did not start programming");
  AST_USER: assert property (s_launch ##0 !boot_exec |=> !busy)
    else $error("launch honoured from user flash");
  AST_LEN: assert property ($fell(busy) |-> busy_len_reg == PROG_CYCLES)
    else $error("busy run length wrong");
  AST_AUTOCLR: assert property ($fell(busy) |-> ##[0:1] (!stat_rdata[2] && !stat_rdata[1]))
    else $error("latch or error not cleared after programming");
  AST_MANUAL: assert property (s_pair(8'h56, 8'hA6) ##0 boot_exec |-> ##[1:2] !stat_rdata[2])
    else $error("latch reset keys did not empty latch");
  AST_SEQUENCE_ERROR_FLAG: assert property (ctrl_we && !busy && key_reg[7:4] == 4'h5 && ctrl_wdata[7:4] != 4'hA
    |-> ##[1:2] stat_rdata[1]) else $error("broken key pair not flagged");
  AST_EMPTY: assert property (s_launch ##0 (boot_exec && !stat_rdata[2]) |-> ##1 !busy ##[0:1] stat_rdata[1])
    else $error("empty launch not refused");
  AST_SWCLR: assert property (stat_we && !stat_wdata[1] && !ctrl_we && !$past(ctrl_we) |=> !stat_rdata[1])
    else $error("status write did not clear error");
  AST_FREEZE: assert property (busy && $past(busy) |-> stat_rdata[2] == $past(stat_rdata[2]))
    else $error("latch changed while busy");
endmodule // flash_seq_properties
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the core end and sequencer end pair
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int PROG = 40;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, irq, done;
  logic [7:0] sec, d;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] prog_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  integer seed = 32'hd37e;
  flash_seq_if bus_if();
  flash_core_master flash_core_master_i(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .bus(bus_if));
  flash_program_sequencer #(.PROG_CYCLES(PROG)) flash_program_sequencer_i(.clk_i(clk_i), .rst_i(rst_i),
    .bus(bus_if), .security_byte_o(sec), .prog_done_o(done));
  flash_seq_properties #(.PROG_CYCLES(PROG)) flash_seq_properties_i(.clk_i(clk_i), .rst_i(rst_i),
    .ctrl_we(bus_if.ctrl_we), .ctrl_wdata(bus_if.ctrl_wdata), .stat_we(bus_if.stat_we),
    .stat_wdata(bus_if.stat_wdata), .latch_we(bus_if.latch_we), .latch_addr(bus_if.latch_addr),
    .boot_exec(bus_if.boot_exec), .ctrl_rdata(bus_if.ctrl_rdata), .stat_rdata(bus_if.stat_rdata));
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  task automatic cmp(input logic [32:0] got, input logic [32:0] want);
    num_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one classic cycle; idle after it so the core's three key cycles never meet a new command
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, v};
    @(posedge clk_i);
    while (ack !== 1'h1) @(posedge clk_i);
    cyc <= 1'h0;
    stb <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    wb(1'h1, a, v);
  endtask
  task automatic rd(input logic [3:0] a, input logic xi, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({xi, x});
    msk_q.push_back(m);
    wb(1'h0, a, 8'h00);
  endtask
  task automatic st(input logic xi, input logic [31:0] x);
    rd(4'h8, xi, x, 32'h7);
  endtask
  // results are matched in order against the notes left by the driver
  always @(posedge clk_i) begin
    if (ack === 1'h1 && we === 1'h0) cmp({irq, rdat & msk_q.pop_front()}, exp_q.pop_front());
    if (done === 1'h1) cmp({25'h0, sec}, {25'h0, prog_q.pop_front()});
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    wr(4'h0, 8'h81);
    rd(4'h8, 1'h0, 32'h0C00, 32'hFF00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      wr(4'h1, {7'h0, i != 1});
      wr(4'h4, d);
      wr(4'h0, 8'h82);
      st(1'h0, 32'h4);
      prog_q.push_back(d);
      wr(4'h0, 8'h83);
      st(1'h0, 32'h5);
      wr(4'h0, 8'h84);
      st(1'h0, 32'h5);
      @(posedge clk_i iff done === 1'h1);
      st(i != 1, 32'h0);
      rd(4'hC, i != 1, 32'h1, 32'h1);
      wr(4'hC, 8'h01);
      rd(4'hC, 1'h0, 32'h0, 32'h1);
    end
    // mask read-back: mask bits above, key issue bit idle
    rd(4'h1, 1'h0, 32'h200, 32'h608);
    // launch with empty latch, error interrupt, then software clear
    wr(4'h0, 8'h83);
    st(1'h0, 32'h2);
    wr(4'h1, 8'h02);
    rd(4'hC, 1'h1, 32'h2, 32'h2);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h85);
    st(1'h0, 32'h0);
    // first key followed by a foreign value, then a lone second key
    wr(4'h4, 8'h54);
    wr(4'h0, 8'h86);
    wr(4'h4, 8'h12);
    wr(4'h0, 8'h86);
    st(1'h0, 32'h2);
    wr(4'h0, 8'h85);
    wr(4'h4, 8'hA4);
    wr(4'h0, 8'h86);
    st(1'h0, 32'h0);
    // unmapped load dropped; mapped load, manual reset, then user flash keys
    wr(4'h0, 8'h82);
    st(1'h0, 32'h0);
    wr(4'h0, 8'h81);
    wr(4'h0, 8'h82);
    wr(4'h0, 8'h84);
    st(1'h0, 32'h0);
    wr(4'h0, 8'h82);
    wr(4'h0, 8'h03);
    st(1'h0, 32'h4);
    wr(4'h0, 8'h04);
    st(1'h0, 32'h4);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
